// ==== hdl/hsc_pkg.sv ====
// shared constants and types of the counter load-values loader
// assumes one 25 MHz clock and a host that writes 16-bit words
package hsc_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int WORDS = 6;                 // words in each word block
  localparam int CLOCK_PERIOD_NS = 40;      // 25 MHz module clock
  localparam int EXEC_TIME_US = 1000;       // command execution time
  localparam int MS_TIME_US = 1000;         // one millisecond
  localparam int EXEC_CYCLES = (EXEC_TIME_US * 1000) / CLOCK_PERIOD_NS;
  localparam int MS_CYCLES = (MS_TIME_US * 1000) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // word indices inside the output word block
  // ----------------------------------------------------------------
  localparam logic [2:0] W_CMD = 3'h0;      // command word
  localparam logic [2:0] W_P1 = 3'h1;       // load_param_word_1
  localparam logic [2:0] W_P2 = 3'h2;       // load_param_word_2
  localparam logic [2:0] W_P3 = 3'h3;       // load_param_word_3
  localparam logic [2:0] W_P4 = 3'h4;       // load_param_word_4
  localparam logic [2:0] W_AT = 3'h5;       // assert_time_word

  // ----------------------------------------------------------------
  // command codes (high byte of the command word)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CONFIG = 8'h01;
  localparam logic [7:0] CMD_LOAD = 8'h02;
  localparam logic [7:0] CMD_READ_CNT = 8'h03;
  localparam logic [7:0] CMD_READ_RATE = 8'h04;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_MODE_LSB = 11;         // bits 11 and 12 of word 1
  localparam logic [1:0] MODE_TWO16 = 2'h0; // two 16-bit, assert on
  localparam logic [1:0] MODE_ONE32 = 2'h1; // one 32-bit, assert on
  localparam logic [1:0] MODE_TWO32 = 2'h2; // two 32-bit, no assert
  localparam logic [1:0] MODE_RATE = 2'h3;  // rate sample
  localparam logic [3:0] OUT_TIMED_A = 4'h5; // timed output modes
  localparam logic [3:0] OUT_TIMED_B = 4'h6;
  localparam logic [3:0] OUT_PULSE_MAX = 4'h4; // 1..4 one-count pulse

  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] LIM_16 = 32'h0000ffff;
  localparam logic [31:0] LIM_32 = 32'h07ffffff;
  localparam logic [13:0] LIM_MS = 14'h3fff;
  localparam int STATUS_FAULT_BIT = 7;      // msb of the map status byte
  localparam int RESP_POWER_BIT = 8;        // field power flag in word 5

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code;   // command definition byte
    logic rsv7;
    logic dis2;         // 1 = disable counter 2
    logic pre2;         // 1 = preset counter 2
    logic en2;          // 1 = enable counter 2
    logic rsv3;
    logic dis1;         // 1 = disable counter 1
    logic pre1;         // 1 = preset counter 1
    logic en1;          // 1 = enable counter 1
  } hsc_cmd_t;

  typedef enum logic [1:0] {
    RESP_COUNT,
    RESP_RATE,
    RESP_ECHO
  } hsc_resp_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } hsc_state_t;

endpackage

// ==== hdl/hsc_chan.sv ====
// one counter channel: up counter with setpoint and rollover, plus
// a rate sampler; assumes a one-cycle millisecond tick from outside
`timescale 1ns/100ps
`default_nettype none

module hsc_chan (
  input wire logic i_clock,          // module clock
  input wire logic i_rst,            // synchronous reset, high
  input wire logic i_run,            // counter enabled
  input wire logic i_preset,         // preset count to zero
  input wire logic i_pulse,          // one count event
  input wire logic i_ms_tick,        // millisecond tick
  input wire logic [31:0] i_max,     // maximum count
  input wire logic [31:0] i_setpt,   // setpoint
  input wire logic [13:0] i_interval, // sample interval in ms
  output logic [31:0] o_count,       // live count
  output logic [31:0] o_rate,        // last sampled rate
  output logic o_at_setpt,           // count sits at setpoint
  output logic o_at_roll             // count sits at zero after rollover
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] count_q;   // live count
  logic wrapped_q;        // last step was a rollover
  logic [31:0] acc_q;     // pulses in the running sample
  logic [13:0] ms_q;      // ms into the running sample
  logic [31:0] rate_q;    // last finished sample

  // counting: up to max, then back to zero
  always_ff @(posedge i_clock) begin
    if (i_rst || i_preset) begin
      count_q <= 32'h00000000;
      wrapped_q <= 1'b0;
    end else if (i_run && i_pulse) begin
      if (count_q >= i_max) begin
        count_q <= 32'h00000000;
        wrapped_q <= 1'b1;
      end else begin
        count_q <= count_q + 32'h00000001;
        wrapped_q <= 1'b0;
      end
    end
  end

  // rate sampling: pulses counted over the interval, then latched
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc_q <= 32'h00000000;
      ms_q <= 14'h0000;
      rate_q <= 32'h00000000;
    end else if (!i_run || i_interval == 14'h0000) begin
      // a stopped channel restarts its sample from scratch
      acc_q <= 32'h00000000;
      ms_q <= 14'h0000;
    end else if (i_ms_tick && ms_q + 14'h0001 >= i_interval) begin
      rate_q <= acc_q + {31'h00000000, i_pulse};
      acc_q <= 32'h00000000;
      ms_q <= 14'h0000;
    end else begin
      acc_q <= acc_q + {31'h00000000, i_pulse};
      if (i_ms_tick) begin
        ms_q <= ms_q + 14'h0001;
      end
    end
  end

  assign o_count = count_q;
  assign o_rate = rate_q;
  // a zero setpoint never fires, it would collide with rollover
  assign o_at_setpt = (count_q == i_setpt) && (i_setpt != 32'h0);
  assign o_at_roll = wrapped_q && (count_q == 32'h00000000);

endmodule

`default_nettype wire

// ==== hdl/hsc_loader.sv ====
// top of the counter load-values loader: six host-written command
// words, six response words, two counter channels and four outputs;
// assumes the host writes whole words synchronous to the clock
`timescale 1ns/100ps
`default_nettype none

// Contract
// - single on-time value serves one output only
// - first timed output runs, other timed disabled
// - load format follows configured counter mode
// - 16-bit mode: word 1 is counter 1 max
// - 16-bit mode: word 2 is counter 1 setpoint
// - 16-bit mode: words 3,4 counter 2 max/setpoint
// - assert modes: word 5 on-time ms, 3fff
// - zero parameter word leaves value unchanged
// - zero 32-bit pair leaves value unchanged
// - one-32 mode: max from words 1,2
// - one-32 mode: setpoint from words 3,4
// - two-32 mode: no assert, counter 2 max
// - rate mode: word 1 counter 1 interval
// - rate mode: word 2 counter 2 interval
// - command bits disable, preset, enable counters
// - status msb flags fuse or supply loss
// - output pulses one count at setpoint
// - rollover to zero pulses second output
// - undefined commands show live counts or rates
// - counter runs with hardware and software enable
// - echo words, low byte cleared, after 1 ms
// - every command carries channel control bits
module hsc_loader #(
  parameter int EXEC_CYCLES = hsc_pkg::EXEC_CYCLES, // exec time, cycles
  parameter int MS_CYCLES = hsc_pkg::MS_CYCLES      // one ms, cycles
) (
  input wire logic i_clock,                // module clock, 25 MHz
  input wire logic i_rst,                  // synchronous reset, high
  input wire logic i_wr_en,                // write one output word
  input wire logic [2:0] i_wr_idx,         // word index 0..5
  input wire logic [15:0] i_wr_data,       // word value
  input wire logic i_exec,                 // execute command word
  input wire logic [1:0] i_cnt_pulse,      // count events per channel
  input wire logic [1:0] i_hw_enable,      // hardware enable inputs
  input wire logic [1:0] i_hw_preset,      // hardware preset inputs
  input wire logic i_supply_fault,         // fuse blown or supply lost
  output logic [5:0][15:0] o_resp_word,    // input word block
  output logic [7:0] o_map_status,         // map status byte
  output logic o_busy,                     // command in execution
  output logic [3:0] o_out                 // outputs 1a,1b,2a,2b
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] word_q [hsc_pkg::WORDS];  // output word block
  logic [5:0] written_q;                 // words written since exec
  hsc_pkg::hsc_state_t state_q;          // execution state
  logic [31:0] exec_cnt_q;               // execution timer
  logic [31:0] tick_cnt_q;               // ms prescaler
  logic ms_tick_q;                       // one-cycle ms tick
  logic [1:0] mode_q;                    // counter or rate mode
  logic [15:0] outmode_q;                // four output mode nibbles
  logic [31:0] max_q [2];                // maximum counts
  logic [31:0] setpt_q [2];              // setpoints
  logic [13:0] interval_q [2];           // rate sample intervals
  logic [13:0] atime_q;                  // output on time, ms
  logic [1:0] sw_en_q;                   // software enables
  logic [1:0] sw_pre_q;                  // software preset pulses
  hsc_pkg::hsc_resp_t resp_q;            // response source
  logic [15:0] echo_q [hsc_pkg::WORDS];  // echoed words
  logic [13:0] on_ms_q;                  // timed output remaining
  logic [3:0] ev_q;                      // previous output events
  logic [31:0] count [2];                // channel counts
  logic [31:0] rate [2];                 // channel rates
  logic [3:0] ev;                        // raw events 1a,1b,2a,2b
  logic [3:0] timed;                     // outputs in a timed mode
  logic [3:0] first_timed;               // the one timed output kept
  logic assert_ok;                       // mode allows outputs
  logic done;                            // execution completes now
  hsc_pkg::hsc_cmd_t cmd;                // command word view
  logic [31:0] pair_a;                   // words 1,2 as low:high
  logic [31:0] pair_b;                   // words 3,4 as low:high

  assign cmd = hsc_pkg::hsc_cmd_t'(word_q[hsc_pkg::W_CMD]);
  assign done = (state_q == hsc_pkg::ST_EXEC) &&
                (exec_cnt_q == 32'(EXEC_CYCLES - 1));
  assign pair_a = {word_q[hsc_pkg::W_P2], word_q[hsc_pkg::W_P1]};
  assign pair_b = {word_q[hsc_pkg::W_P4], word_q[hsc_pkg::W_P3]};

  // clamp a value to a limit
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // clamp a word to the millisecond limit
  function automatic logic [13:0] clamp_ms(input logic [15:0] v);
    clamp_ms = (v > {2'h0, hsc_pkg::LIM_MS}) ? hsc_pkg::LIM_MS :
               v[13:0];
  endfunction

  // ----------------------------------------------------------------
  // host side word block
  // ----------------------------------------------------------------

  // stores each host word; a write in the finishing cycle still
  // counts toward the next command, so set wins over clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < hsc_pkg::WORDS; i++) begin
        word_q[i] <= 16'h0000;
      end
      written_q <= 6'h00;
    end else begin
      for (int i = 0; i < hsc_pkg::WORDS; i++) begin
        if (i_wr_en && i_wr_idx == 3'(i)) begin
          word_q[i] <= i_wr_data;
          written_q[i] <= 1'b1;
        end else if (done) begin
          written_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------

  // millisecond prescaler for on times and rate samples
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tick_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(MS_CYCLES - 1)) begin
      tick_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      ms_tick_q <= 1'b0;
    end
  end

  // execution sequencer: a request while busy is ignored
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= hsc_pkg::ST_IDLE;
      exec_cnt_q <= 32'h00000000;
    end else begin
      unique case (state_q)
        hsc_pkg::ST_IDLE: begin
          exec_cnt_q <= 32'h00000000;
          if (i_exec) begin
            state_q <= hsc_pkg::ST_EXEC;
          end
        end
        hsc_pkg::ST_EXEC: begin
          if (done) begin
            state_q <= hsc_pkg::ST_IDLE;
          end else begin
            exec_cnt_q <= exec_cnt_q + 32'h00000001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------

  // configure command sets the mode and output modes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_q <= hsc_pkg::MODE_TWO16;
      outmode_q <= 16'h0000;
    end else if (done && cmd.code == hsc_pkg::CMD_CONFIG) begin
      mode_q <= word_q[hsc_pkg::W_P1][hsc_pkg::CFG_MODE_LSB +: 2];
      outmode_q <= word_q[hsc_pkg::W_P2];
    end
  end

  // load values; the layout depends on the configured mode and a
  // zero word or zero pair keeps the stored value
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      max_q[0] <= hsc_pkg::LIM_16;
      max_q[1] <= hsc_pkg::LIM_16;
      setpt_q[0] <= 32'h00000000;
      setpt_q[1] <= 32'h00000000;
      interval_q[0] <= 14'h0000;
      interval_q[1] <= 14'h0000;
      atime_q <= 14'h0000;
    end else if (done && cmd.code == hsc_pkg::CMD_LOAD) begin
      unique case (mode_q)
        hsc_pkg::MODE_TWO16: begin
          if (word_q[hsc_pkg::W_P1] != 16'h0000) begin
            max_q[0] <= {16'h0000, word_q[hsc_pkg::W_P1]};
          end
          if (word_q[hsc_pkg::W_P2] != 16'h0000) begin
            setpt_q[0] <= {16'h0000, word_q[hsc_pkg::W_P2]};
          end
          if (word_q[hsc_pkg::W_P3] != 16'h0000) begin
            max_q[1] <= {16'h0000, word_q[hsc_pkg::W_P3]};
          end
          if (word_q[hsc_pkg::W_P4] != 16'h0000) begin
            setpt_q[1] <= {16'h0000, word_q[hsc_pkg::W_P4]};
          end
        end
        hsc_pkg::MODE_ONE32: begin
          if (pair_a != 32'h0 && written_q[2:1] == 2'h3) begin
            max_q[0] <= clamp(pair_a, hsc_pkg::LIM_32);
          end
          if (pair_b != 32'h0 && written_q[4:3] == 2'h3) begin
            setpt_q[0] <= clamp(pair_b, hsc_pkg::LIM_32);
          end
        end
        hsc_pkg::MODE_TWO32: begin
          if (pair_a != 32'h0 && written_q[2:1] == 2'h3) begin
            max_q[0] <= clamp(pair_a, hsc_pkg::LIM_32);
          end
          if (pair_b != 32'h0 && written_q[4:3] == 2'h3) begin
            max_q[1] <= clamp(pair_b, hsc_pkg::LIM_32);
          end
        end
        hsc_pkg::MODE_RATE: begin
          if (word_q[hsc_pkg::W_P1] != 16'h0000) begin
            interval_q[0] <= clamp_ms(word_q[hsc_pkg::W_P1]);
          end
          if (word_q[hsc_pkg::W_P2] != 16'h0000) begin
            interval_q[1] <= clamp_ms(word_q[hsc_pkg::W_P2]);
          end
        end
      endcase
      // on time only exists where outputs can assert
      if (!mode_q[1] && word_q[hsc_pkg::W_AT] != 16'h0000) begin
        atime_q <= clamp_ms(word_q[hsc_pkg::W_AT]);
      end
    end
  end

  // control bits ride on every command; disable beats enable
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sw_en_q <= 2'h0;
      sw_pre_q <= 2'h0;
    end else begin
      sw_pre_q <= done ? {cmd.pre2, cmd.pre1} : 2'h0;
      if (done) begin
        if (cmd.dis1) begin
          sw_en_q[0] <= 1'b0;
        end else if (cmd.en1) begin
          sw_en_q[0] <= 1'b1;
        end
        if (cmd.dis2) begin
          sw_en_q[1] <= 1'b0;
        end else if (cmd.en2) begin
          sw_en_q[1] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // counter channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    hsc_chan u_chan (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_run(i_hw_enable[c] && sw_en_q[c]),
      .i_preset(i_hw_preset[c] || sw_pre_q[c]),
      .i_pulse(i_cnt_pulse[c]),
      .i_ms_tick(ms_tick_q),
      .i_max(max_q[c]),
      .i_setpt(setpt_q[c]),
      .i_interval(interval_q[c]),
      .o_count(count[c]),
      .o_rate(rate[c]),
      .o_at_setpt(ev[2 * c]),
      .o_at_roll(ev[2 * c + 1])
    );
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // only the first timed output in 1a,1b,2a,2b order keeps the one
  // shared on time; the rest are held off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      timed[i] = (outmode_q[15 - 4 * i -: 4] == hsc_pkg::OUT_TIMED_A) ||
                 (outmode_q[15 - 4 * i -: 4] == hsc_pkg::OUT_TIMED_B);
    end
    first_timed = timed & (~timed + 4'h1);
  end

  // two 32-bit counters and rate sampling have no output assertion
  assign assert_ok = !mode_q[1];

  // timed output: restarted by its event, lasts the on time
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      on_ms_q <= 14'h0000;
      ev_q <= 4'h0;
    end else begin
      ev_q <= ev;
      if (|(first_timed & ev & ~ev_q)) begin
        on_ms_q <= atime_q;
      end else if (ms_tick_q && on_ms_q != 14'h0000) begin
        on_ms_q <= on_ms_q - 14'h0001;
      end
    end
  end

  // per-output drive: one-count pulse modes follow the event level
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_out <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!assert_ok) begin
          o_out[i] <= 1'b0;
        end else if (timed[i]) begin
          o_out[i] <= first_timed[i] && on_ms_q != 14'h0000;
        end else begin
          o_out[i] <= ev[i] && outmode_q[15 - 4 * i -: 4] != 4'h0 &&
                      outmode_q[15 - 4 * i -: 4] <= hsc_pkg::OUT_PULSE_MAX;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // response words and status
  // ----------------------------------------------------------------

  // picks the response source when a command finishes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      resp_q <= hsc_pkg::RESP_COUNT;
      for (int i = 0; i < hsc_pkg::WORDS; i++) begin
        echo_q[i] <= 16'h0000;
      end
    end else if (done) begin
      if (cmd.code == hsc_pkg::CMD_CONFIG ||
          cmd.code == hsc_pkg::CMD_LOAD) begin
        resp_q <= hsc_pkg::RESP_ECHO;
        echo_q[0] <= {cmd.code, 8'h00};
        for (int i = 1; i < hsc_pkg::WORDS; i++) begin
          echo_q[i] <= word_q[i];
        end
      end else if (cmd.code == hsc_pkg::CMD_READ_RATE ||
                   (cmd.code != hsc_pkg::CMD_READ_CNT &&
                    mode_q == hsc_pkg::MODE_RATE)) begin
        resp_q <= hsc_pkg::RESP_RATE;
      end else begin
        resp_q <= hsc_pkg::RESP_COUNT;
      end
    end
  end

  // live response words, refreshed every cycle outside echo
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_resp_word <= '0;
    end else if (resp_q == hsc_pkg::RESP_ECHO) begin
      for (int i = 0; i < hsc_pkg::WORDS; i++) begin
        o_resp_word[i] <= echo_q[i];
      end
    end else begin
      o_resp_word[0] <= {cmd.code, 8'h00};
      for (int c = 0; c < 2; c++) begin
        if (resp_q == hsc_pkg::RESP_RATE) begin
          o_resp_word[2 * c + 1] <= rate[c][15:0];
          o_resp_word[2 * c + 2] <= rate[c][31:16];
        end else begin
          o_resp_word[2 * c + 1] <= count[c][15:0];
          o_resp_word[2 * c + 2] <= count[c][31:16];
        end
      end
      o_resp_word[5] <= 16'h0000;
      o_resp_word[5][hsc_pkg::RESP_POWER_BIT] <= i_supply_fault;
    end
  end

  // status byte and busy flag
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_map_status <= 8'h00;
      o_busy <= 1'b0;
    end else begin
      o_map_status <= 8'h00;
      o_map_status[hsc_pkg::STATUS_FAULT_BIT] <= i_supply_fault;
      o_busy <= (state_q == hsc_pkg::ST_EXEC) && !done;
    end
  end

endmodule

`default_nettype wire

// ==== verification/hsc_loader_sva.sv ====
// checker on the loader ports: busy span, echo, status byte
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module hsc_loader_sva #(
  parameter int EXEC_CYCLES = 8 // exec time in cycles
) (
  input wire logic i_clock, // module clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_wr_en, // word write
  input wire logic [2:0] i_wr_idx, // word index
  input wire logic [15:0] i_wr_data, // word value
  input wire logic i_exec, // start command
  input wire logic i_supply_fault, // fault input
  input wire logic [5:0][15:0] o_resp_word, // response words
  input wire logic [7:0] o_map_status, // status byte
  input wire logic o_busy, // executing
  input wire logic [3:0] o_out // outputs
);
  logic [15:0] cmd_q; // last command word written
  logic [31:0] bcnt_q; // busy cycles seen so far
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // counters live here so the repetition bound stays a parameter
  always_ff @(posedge i_clock) begin
    bcnt_q <= (i_rst || !o_busy) ? '0 : bcnt_q + 32'h1;
    if (i_wr_en && i_wr_idx == 3'h0) cmd_q <= i_wr_data;
  end
  // busy rises one edge after the edge that takes the start
  AST_BUSY_CAUSE: assert property ($rose(o_busy) |-> $past(i_exec, 2))
    else $error("busy rose with no start");
  AST_BUSY_LEN: assert property ($fell(o_busy) |->
    bcnt_q == EXEC_CYCLES - 1) else $error("busy span wrong");
  AST_IDLE_HOLD: assert property (!o_busy && !i_exec && !$past(i_exec)
    |=> !o_busy) else $error("busy with no start");
  AST_ECHO: assert property ($fell(o_busy) &&
    cmd_q[15:8] inside {8'h01, 8'h02} |-> ##2
    o_resp_word[0] == {cmd_q[15:8], 8'h00}) else $error("bad echo");
  AST_STAT_SET: assert property (i_supply_fault |=> o_map_status[7])
    else $error("fault not flagged");
  AST_STAT_CLR: assert property (!i_supply_fault |=> !o_map_status[7])
    else $error("fault flag stuck");
  AST_STAT_RSV: assert property (o_map_status[6:0] == 7'h00)
    else $error("status low bits set");
  AST_RESET_CLEAN: assert property ($fell(i_rst) |-> !o_busy &&
    o_out == 4'h0 && o_resp_word == '0) else $error("state after reset");
  cover property ($fell(o_busy));
  cover property (o_out[0]);
  cover property (o_map_status[7]);
endmodule
bind hsc_loader hsc_loader_sva #(.EXEC_CYCLES(EXEC_CYCLES)) sva_u (.i_clock,
  .i_rst, .i_wr_en, .i_wr_idx, .i_wr_data, .i_exec, .i_supply_fault,
  .o_resp_word, .o_map_status, .o_busy, .o_out);
`default_nettype wire

// ==== verification/hsc_host_model.sv ====
// host model: fills the output word block and starts commands
// assumes the loader reads words at completion and shows o_busy
`timescale 1ns/100ps
`default_nettype none
module hsc_host_model (
  input wire logic i_clock, // module clock
  input wire logic i_busy, // command executing
  output logic o_wr_en, // word write
  output logic [2:0] o_wr_idx, // word index
  output logic [15:0] o_wr_data, // word value
  output logic o_exec // start command
);
  initial {o_wr_en, o_wr_idx, o_wr_data, o_exec} = '0;
  // six words with random idle gaps, one start, then wait for busy to fall and three cycles more;
  // idle data is scrambled so nothing can lean on a stale word
  task automatic run(input logic [5:0][15:0] w);
    for (int i = 0; i < 6; i++) begin
      @(negedge i_clock);
      {o_wr_en, o_wr_idx, o_wr_data} = {1'b1, 3'(i), w[i]};
      repeat ($urandom_range(1, 0)) begin
        @(negedge i_clock);
        {o_wr_en, o_wr_data} = {1'b0, ~o_wr_data};
      end
    end
    @(negedge i_clock);
    {o_wr_en, o_wr_data, o_exec} = {1'b0, ~o_wr_data, 1'b1};
    @(negedge i_clock);
    o_exec = 1'b0;
    // busy only shows one edge after the start is taken
    @(negedge i_clock);
    for (int k = 0; k < 40 && i_busy; k++)
      @(negedge i_clock);
    repeat (3) @(negedge i_clock);
  endtask
endmodule
`default_nettype wire

// ==== verification/hsc_loader_tb_top.sv ====
// top bench of the loader: host model, counter stimulus, checks
// assumes short exec and ms counts so the run stays brief
`timescale 1ns/100ps
`default_nettype none
module hsc_loader_tb_top;
  logic i_clock = 1'b0; // 25 MHz clock
  logic i_rst = 1'b1; // held ten cycles
  logic [1:0] cnt_pulse = 2'h0, hw_en = 2'h0; // counter inputs
  logic fault = 1'b0, f = 1'b0; // fault input and its copy
  logic wr_en, ex, busy; // host strobes
  logic [2:0] wr_idx; // word index
  logic [15:0] wr_data, c = 16'h0; // word value, expected count 1
  logic [5:0][15:0] resp; // response words
  logic [7:0] stat; // status byte
  logic [3:0] outs; // outputs
  int n_mismatch = 0, total_checks = 0; // tallies
  always #20 i_clock = ~i_clock;
  hsc_host_model host_u (.i_clock(i_clock), .i_busy(busy), .o_wr_en(wr_en),
    .o_wr_idx(wr_idx), .o_wr_data(wr_data), .o_exec(ex));
  hsc_loader #(.EXEC_CYCLES(8), .MS_CYCLES(10)) dut_u (.i_clock(i_clock),
    .i_rst(i_rst), .i_wr_en(wr_en), .i_wr_idx(wr_idx), .i_wr_data(wr_data),
    .i_exec(ex), .i_cnt_pulse(cnt_pulse), .i_hw_enable(hw_en),
    .i_hw_preset(2'h0), .i_supply_fault(fault), .o_resp_word(resp),
    .o_map_status(stat), .o_busy(busy), .o_out(outs));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // next count of channel 1, rolling to zero at the maximum of five
  function automatic logic [15:0] nxt(logic [15:0] v);
    return (v >= 16'h0005) ? 16'h0000 : v + 16'h0001;
  endfunction
  // config, load, then random count bursts read back by command 0
  initial begin
    void'($urandom(9203));
    repeat (10) @(negedge i_clock);
    i_rst = 1'b0;
    host_u.run({48'h0, 16'h1200, 16'h0000, 16'h0100});
    chk("config echo", 16'h1200, resp[2]);
    host_u.run({48'h0, 16'h0003, 16'h0005, 16'h0203});
    chk("load echo", 16'h0200, resp[0]);
    for (int i = 0; i < 6; i++) begin
      repeat ($urandom_range(9, 1)) begin
        @(negedge i_clock);
        chk("status", {8'h00, f, 7'h00}, {8'h00, stat});
        f = 1'($urandom);
        fault = f;
        hw_en = 2'($urandom);
        cnt_pulse = 2'h3;
        if (hw_en[0]) c = nxt(c);
      end
      @(negedge i_clock);
      cnt_pulse = 2'h0;
      if (i == 3) host_u.run({80'h0, 16'h0241});
      host_u.run(96'h0);
      chk("count 1", c, resp[1]);
      chk("count 2", 16'h0000, resp[3]);
      chk("out 1a", 16'(c == 16'h0003), 16'(outs[0]));
      chk("power", {7'h00, f, 8'h00}, resp[5]);
    end
    // rate mode: 2 ms windows of 10-cycle ticks, a pulse every cycle
    host_u.run({48'h0, 16'h1200, 16'h1800, 16'h0100});
    host_u.run({64'h0, 16'h0002, 16'h0201});
    {cnt_pulse, hw_en} = 4'hf;
    repeat (60) @(negedge i_clock);
    host_u.run(96'h0);
    chk("rate 1", 16'(2 * 10), resp[1]);
    chk("outs", 16'h0000, 16'(outs));
    end_sim();
  end
  // hang guard: far beyond the few hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge i_clock);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
